// >>> verilog/panel_drv_pkg.sv
// panel driver control package: register offsets, field positions, resets
// assumes an 8-bit register port addressed by special-register offset
package panel_drv_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] PANEL_CONTROL_OFS = 8'hB1;
    localparam logic [7:0] PANEL_CLOCK_MODE_CONTROL_OFS = 8'hB2;
    localparam logic [7:0] SEGMENT_PIN_SELECT_OFS = 8'hB3;
    // panel_control fields
    localparam int DRIVER_ENABLE_BIT = 7;
    localparam int DUTY_SELECT_BIT = 6;
    localparam int BIAS_LSB = 0;
    // panel_clock_mode_control fields
    localparam int CLOCK_SOURCE_BIT = 7;
    localparam int DIVIDER_LSB = 5;
    localparam int MATRIX_MODE_BIT = 4;
    localparam int COMMON_POLARITY_BIT = 3;
    localparam int DEAD_TIME_BIT = 2;
    // reset values; writable masks keep unused bits at zero
    localparam logic [7:0] PANEL_CONTROL_RST = 8'h44;
    localparam logic [7:0] PANEL_CONTROL_MASK = 8'hC7;
    localparam logic [7:0] CLOCK_MODE_RST = 8'h00;
    localparam logic [7:0] CLOCK_MODE_MASK = 8'hFC;
    localparam logic [7:0] SEGMENT_PIN_RST = 8'h00;
    // divider counts per code 00..11
    localparam logic [7:0] DIV_256_MAX = 8'hFF;
    localparam logic [7:0] DIV_128_MAX = 8'h7F;
    localparam logic [7:0] DIV_64_MAX = 8'h3F;
    localparam logic [7:0] DIV_32_MAX = 8'h1F;
    // dead time in driver ticks, blanking between commons
    localparam logic [1:0] DEAD_TICKS = 2'h1;
endpackage

// >>> verilog/panel_clk_div.sv
// panel driver clock divider: sync of slow clocks, selection and prescale
// assumes slow clocks far below i_clk; they are sampled as levels
`timescale 1ns/1ps
module panel_clk_div
    import panel_drv_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // slow clocks and control
    input wire logic i_slow_rc_oscillator,
    input wire logic i_slow_crystal_oscillator,
    input wire logic i_source,
    input wire logic [1:0] i_divider,
    input wire logic i_run,
    // one pulse per divided driver clock period
    output logic o_tick
);
    logic [1:0] rc_sync_q, rc_sync_d, xt_sync_q, xt_sync_d;
    logic prev_q, prev_d;
    logic [7:0] cnt_q, cnt_d;
    logic tick_q, tick_d;
    logic sel, rise;
    logic [7:0] top;

    always_comb begin
        rc_sync_d = {rc_sync_q[0], i_slow_rc_oscillator};
        xt_sync_d = {xt_sync_q[0], i_slow_crystal_oscillator};
        sel = i_source ? xt_sync_q[1] : rc_sync_q[1];
        rise = sel & ~prev_q;
        prev_d = sel;
        unique case (i_divider)
            2'b00: top = DIV_256_MAX;
            2'b01: top = DIV_128_MAX;
            2'b10: top = DIV_64_MAX;
            2'b11: top = DIV_32_MAX;
        endcase
        cnt_d = cnt_q;
        tick_d = 1'b0;
        if (!i_run) begin
            cnt_d = 8'h00;
        end else if (rise) begin
            if (cnt_q >= top) begin
                cnt_d = 8'h00;
                tick_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 8'h01;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rc_sync_q <= 2'h0;
            xt_sync_q <= 2'h0;
            prev_q <= 1'b0;
            cnt_q <= 8'h00;
            tick_q <= 1'b0;
        end else begin
            rc_sync_q <= rc_sync_d;
            xt_sync_q <= xt_sync_d;
            prev_q <= prev_d;
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign o_tick = tick_q;

    a_tick_gated: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !i_run |=> !o_tick) else $error("tick while stopped");
    c_tick: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_tick);
endmodule

// >>> verilog/panel_drv_ctrl.sv
// panel driver control registers and common/segment pin steering
// assumes an 8-bit register port, read data one cycle after the strobe
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module panel_drv_ctrl
    import panel_drv_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // register port
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // slow clocks
    input wire logic i_slow_rc_oscillator,
    input wire logic i_slow_crystal_oscillator,
    // panel side
    output logic [3:0] o_common,
    output logic o_common_oe,
    output logic o_matrix_mode_select,
    output logic [2:0] o_bias_level_select,
    output logic o_frame_tick,
    // segment pin function, bit n = segment n+4 drives panel
    output logic [13:0] o_segment_pin_mode
);
    logic [7:0] ctl_q, ctl_d, ckm_q, ckm_d, pin_q, pin_d;
    logic [7:0] rdata_q, rdata_d;
    logic [1:0] com_q, com_d;
    logic [1:0] dead_q, dead_d;
    logic [3:0] common_q, common_d;
    logic tick;
    logic run, duty4, led, pol, dte;
    logic [3:0] active;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    // register file
    always_comb begin
        ctl_d = ctl_q;
        ckm_d = ckm_q;
        pin_d = pin_q;
        rdata_d = 8'h00;
        if (i_wr) begin
            if (hit(i_addr, PANEL_CONTROL_OFS))
                ctl_d = i_wdata & PANEL_CONTROL_MASK;
            if (hit(i_addr, PANEL_CLOCK_MODE_CONTROL_OFS))
                ckm_d = i_wdata & CLOCK_MODE_MASK;
            if (hit(i_addr, SEGMENT_PIN_SELECT_OFS))
                pin_d = i_wdata;
        end
        if (i_rd) begin
            if (hit(i_addr, PANEL_CONTROL_OFS))
                rdata_d = ctl_q;
            else if (hit(i_addr, PANEL_CLOCK_MODE_CONTROL_OFS))
                rdata_d = ckm_q;
            else if (hit(i_addr, SEGMENT_PIN_SELECT_OFS))
                rdata_d = pin_q;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctl_q <= PANEL_CONTROL_RST;
            ckm_q <= CLOCK_MODE_RST;
            pin_q <= SEGMENT_PIN_RST;
            rdata_q <= 8'h00;
        end else begin
            ctl_q <= ctl_d;
            ckm_q <= ckm_d;
            pin_q <= pin_d;
            rdata_q <= rdata_d;
        end
    end

    assign o_rdata = rdata_q;

    assign run = ctl_q[DRIVER_ENABLE_BIT];
    assign duty4 = ctl_q[DUTY_SELECT_BIT];
    assign led = ckm_q[MATRIX_MODE_BIT];
    assign pol = ckm_q[COMMON_POLARITY_BIT];
    assign dte = ckm_q[DEAD_TIME_BIT];
    assign o_matrix_mode_select = led;
    assign o_bias_level_select = ctl_q[BIAS_LSB+:3];

    panel_clk_div u_div (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_slow_rc_oscillator(i_slow_rc_oscillator),
        .i_slow_crystal_oscillator(i_slow_crystal_oscillator),
        .i_source(ckm_q[CLOCK_SOURCE_BIT]),
        .i_divider(ckm_q[DIVIDER_LSB+:2]),
        .i_run(run),
        .o_tick(tick)
    );
    assign o_frame_tick = tick;

    // common scan: one common per tick, dead time blanks before the next
    always_comb begin
        com_d = com_q;
        dead_d = dead_q;
        if (!run) begin
            com_d = 2'h0;
            dead_d = 2'h0;
        end else if (tick) begin
            if (dead_q != 2'h0) begin
                dead_d = dead_q - 2'h1;
            end else begin
                com_d = (duty4 ? com_q == 2'h3 : com_q == 2'h2) ? 2'h0
                        : com_q + 2'h1;
                dead_d = (led && dte) ? DEAD_TICKS : 2'h0;
            end
        end
        // a pending blank is dropped at once when dead time is switched off
        if (!(led && dte)) begin
            dead_d = 2'h0;
        end
        active = (run && dead_q == 2'h0) ? (4'h1 << com_q) : 4'h0;
        if (led)
            common_d = pol ? active : ~active;
        else
            common_d = active;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            com_q <= 2'h0;
            dead_q <= 2'h0;
            common_q <= 4'h0;
        end else begin
            com_q <= com_d;
            dead_q <= dead_d;
            common_q <= common_d;
        end
    end

    assign o_common = common_q;
    assign o_common_oe = run;

    // segment pin steering
    generate
        for (genvar g = 0; g < 6; g++) begin : g_single
            assign o_segment_pin_mode[8+g] = pin_q[2+g];
        end
    endgenerate
    // pin bit 1 selects segments 8 to 11 together when set
    assign o_segment_pin_mode[7:4] = {4{pin_q[1]}};
    assign o_segment_pin_mode[3:0] = {4{pin_q[0]}};

    a_seg_group: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_wr && hit(i_addr, SEGMENT_PIN_SELECT_OFS) |=>
        o_segment_pin_mode == {$past(i_wdata[7:2]),
            {4{$past(i_wdata[1])}}, {4{$past(i_wdata[0])}}})
        else $error("segment mode mismatch");
    a_readback: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_rd && hit(i_addr, SEGMENT_PIN_SELECT_OFS) && !i_wr |=>
        o_rdata == $past(pin_q)) else $error("readback wrong");
    a_off_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !run ##1 !run |->
        o_common == (($past(led) && !$past(pol)) ? 4'hF : 4'h0))
        else $error("commons active while off");
    a_mode_out: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_wr && hit(i_addr, PANEL_CLOCK_MODE_CONTROL_OFS) |=>
        o_matrix_mode_select == $past(i_wdata[MATRIX_MODE_BIT]))
        else $error("mode output wrong");
    a_no_dead: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !dte |-> dead_q == 2'h0 || $past(dte))
        else $error("dead time without enable");
    a_duty3: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        run && !duty4 && com_q == 2'h2 && tick && dead_q == 2'h0 |=>
        com_q == 2'h0) else $error("1/3 duty wrap");
    a_led_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        led && !pol && run && dead_q == 2'h0 ##1 $stable(ckm_q) |->
        $countones(o_common) == 3) else $error("active low common");
    a_src_sel: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_wr && hit(i_addr, PANEL_CLOCK_MODE_CONTROL_OFS) |=>
        ckm_q[CLOCK_SOURCE_BIT] == $past(i_wdata[7]))
        else $error("source bit lost");
    a_div_code: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_wr && hit(i_addr, PANEL_CLOCK_MODE_CONTROL_OFS) |=>
        ckm_q[DIVIDER_LSB+:2] == $past(i_wdata[6:5]))
        else $error("divider code lost");
    a_seg_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !i_wr |=> $stable(o_segment_pin_mode))
        else $error("segment mode drift");
    // control readback, enable and the remaining common scan behaviour
    a_ctl_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_rd && hit(i_addr, PANEL_CONTROL_OFS) |=>
        o_rdata == $past(ctl_q))
        else $error("control readback wrong");
    a_ckm_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_rd && hit(i_addr, PANEL_CLOCK_MODE_CONTROL_OFS) |=>
        o_rdata == $past(ckm_q))
        else $error("clock mode readback wrong");
    a_ctl_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_wr && hit(i_addr, PANEL_CONTROL_OFS) |=>
        o_common_oe == $past(i_wdata[DRIVER_ENABLE_BIT]))
        else $error("enable bit lost");
    a_duty4: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        run && duty4 && com_q == 2'h3 && tick && dead_q == 2'h0 |=>
        com_q == 2'h0) else $error("1/4 duty wrap");
    a_one_common: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        run && dead_q == 2'h0 && (!led || pol) |=>
        $countones(o_common) == 1) else $error("not one common");
    a_dead_blank: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        led && run && dead_q != 2'h0 |=>
        o_common == ($past(pol) ? 4'h0 : 4'hF))
        else $error("common lit in dead time");

    c_led_dead: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        led && dte && dead_q != 2'h0);
    c_duty4: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        run && duty4 && com_q == 2'h3);
    c_lcd_run: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        run && !led && tick);
    c_duty3_wrap: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        run && !duty4 && com_q == 2'h2 && tick);
endmodule

// >>> verif/panel_model.sv
// panel glass or led matrix model: tells which commons are energised
// assumes commons straight from the driver, led polarity given by bench
`timescale 1ns/1ps
module panel_model (
    // driver side
    input wire logic [3:0] i_common,
    input wire logic i_common_oe,
    input wire logic i_matrix_mode_select,
    input wire logic i_pol_high,
    // energised commons, bit n is common n
    output logic [3:0] o_active
);
    always_comb begin
        if (!i_common_oe) begin
            o_active = 4'h0;
        end else if (i_matrix_mode_select && !i_pol_high) begin
            o_active = ~i_common;
        end else begin
            o_active = i_common;
        end
    end
endmodule

// >>> verif/tb_top.sv
// bench for panel_drv_ctrl: registers, divider, commons, pin steering
// assumes panel_model beside it; both slow clocks are made here
`timescale 1ns/1ps
module tb_top;
    import panel_drv_pkg::*;
    logic i_clk, i_rst_n, i_wr, i_rd, rc, xt, pol_high;
    logic [7:0] i_addr, i_wdata, o_rdata, rv;
    logic [3:0] o_common, act, rc_cnt, xt_cnt;
    logic o_common_oe, o_matrix_mode_select, o_frame_tick;
    logic [2:0] o_bias_level_select;
    logic [13:0] o_segment_pin_mode;
    int n_fail, checked;
    panel_drv_ctrl i_panel_drv_ctrl (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_slow_rc_oscillator(rc),
        .i_slow_crystal_oscillator(xt), .o_common(o_common),
        .o_common_oe(o_common_oe),
        .o_matrix_mode_select(o_matrix_mode_select),
        .o_bias_level_select(o_bias_level_select),
        .o_frame_tick(o_frame_tick),
        .o_segment_pin_mode(o_segment_pin_mode));
    panel_model i_panel_model (.i_common(o_common),
        .i_common_oe(o_common_oe),
        .i_matrix_mode_select(o_matrix_mode_select),
        .i_pol_high(pol_high), .o_active(act));
    // rc period 8 cycles, crystal period 12 cycles
    always @(posedge i_clk) begin
        rc_cnt <= (rc_cnt == 4'h3) ? 4'h0 : rc_cnt + 4'h1;
        xt_cnt <= (xt_cnt == 4'h5) ? 4'h0 : xt_cnt + 4'h1;
        if (rc_cnt == 4'h3) rc <= ~rc;
        if (xt_cnt == 4'h5) xt <= ~xt;
    end
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
        #1;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk(16'(o_rdata), 16'(e));
    endtask
    task automatic wait_tick();
        int i;
        i = 0;
        @(posedge i_clk);
        #1;
        while (o_frame_tick !== 1'b1 && i < 5000) begin
            @(posedge i_clk);
            #1 i++;
        end
    endtask
    task automatic t_regs();
        rdchk(PANEL_CONTROL_OFS, 8'h44);
        rdchk(PANEL_CLOCK_MODE_CONTROL_OFS, 8'h00);
        rdchk(SEGMENT_PIN_SELECT_OFS, 8'h00);
        chk(16'(o_bias_level_select), 16'h4);
        wr(8'hB0, 8'hFF);
        rdchk(8'hB0, 8'h00);
        wr(PANEL_CONTROL_OFS, 8'hFF);
        rdchk(PANEL_CONTROL_OFS, 8'hC7);
        chk(16'(o_bias_level_select), 16'h7);
        chk(16'(o_common_oe), 16'h1);
        wr(PANEL_CLOCK_MODE_CONTROL_OFS, 8'hFF);
        rdchk(PANEL_CLOCK_MODE_CONTROL_OFS, 8'hFC);
        chk(16'(o_matrix_mode_select), 16'h1);
    endtask
    task automatic t_pins();
        logic [13:0] e;
        // touch sensing is not in use here, so bit 1 may be set
        for (int b = 0; b < 8; b++) begin
            e = (b == 0) ? 14'h000F : (b == 1) ? 14'h00F0 : 14'h1 << (b + 6);
            wr(SEGMENT_PIN_SELECT_OFS, 8'h01 << b);
            chk(16'(o_segment_pin_mode), 16'(e));
        end
        rdchk(SEGMENT_PIN_SELECT_OFS, 8'h80);
    endtask
    task automatic t_div(input logic s, input logic [1:0] c, input int p);
        int n;
        wr(PANEL_CLOCK_MODE_CONTROL_OFS, {s, c, 5'h00});
        wait_tick();
        wait_tick();
        n = 1;
        @(posedge i_clk);
        #1;
        while (o_frame_tick !== 1'b1 && n < 9000) begin
            @(posedge i_clk);
            #1 n++;
        end
        chk(16'(n), 16'((256 >> c) * p));
    endtask
    task automatic t_com(input logic led, input logic pol, input logic dt,
                         input logic duty, input logic [3:0] e_seen,
                         input int e_idle);
        logic [3:0] seen;
        int idle, multi;
        seen = 4'h0;
        idle = 0;
        multi = 0;
        pol_high <= pol;
        wr(PANEL_CONTROL_OFS, {1'b1, duty, 6'h04});
        wr(PANEL_CLOCK_MODE_CONTROL_OFS, {3'b011, led, pol, dt, 2'b00});
        wait_tick();
        for (int k = 0; k < 8; k++) begin
            wait_tick();
            repeat (3) @(posedge i_clk);
            #1 seen |= act;
            if (act === 4'h0) idle++;
            if ($countones(act) > 1) multi++;
        end
        chk(16'(seen), 16'(e_seen));
        chk(16'(idle), 16'(e_idle));
        chk(16'(multi), 16'h0);
    endtask
    task automatic t_off();
        int n;
        n = 0;
        wr(PANEL_CONTROL_OFS, 8'h44);
        repeat (600) begin
            @(posedge i_clk);
            #1 n += (o_frame_tick === 1'b1) ? 1 : 0;
        end
        chk(16'(n), 16'h0);
        chk(16'(o_common_oe), 16'h0);
    endtask
    task automatic close_out();
        if (n_fail == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #(4 * 50000);
        n_fail++;
        close_out();
    end
    initial begin
        {i_rst_n, i_wr, i_rd, rc, xt, pol_high} = 6'h0;
        {i_addr, i_wdata, rc_cnt, xt_cnt} = 24'h0;
        n_fail = 0;
        checked = 0;
        repeat (3) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_regs();
        t_pins();
        wr(PANEL_CONTROL_OFS, 8'hC4);
        for (int c = 0; c < 4; c++) t_div(1'b0, c[1:0], 8);
        t_div(1'b1, 2'h3, 12);
        t_com(1'b0, 1'b0, 1'b0, 1'b1, 4'hF, 0);
        t_com(1'b1, 1'b0, 1'b0, 1'b1, 4'hF, 0);
        t_com(1'b1, 1'b1, 1'b0, 1'b0, 4'h7, 0);
        t_com(1'b1, 1'b1, 1'b1, 1'b1, 4'hF, 4);
        t_off();
        close_out();
    end
endmodule
